/* File: src/icpg_pkg.sv */
package icpg_pkg;

  // Register port widths.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_ICP_WIDTH = 8'h09;
  localparam logic [ADDR_W-1:0] ADDR_OCP_WIDTH = 8'h0a;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h0b;

  // Field positions of the control register.
  localparam int unsigned CTRL_SRC_SEL_BIT    = 0;
  localparam int unsigned CTRL_SYNC_EDGE_BIT  = 1;
  localparam int unsigned CTRL_BLK_INV_BIT    = 2;
  localparam int unsigned CTRL_BLK_EDGE_BIT   = 3;
  localparam int unsigned CTRL_PASS_BIT       = 4;
  localparam int unsigned CTRL_OCP_COPY_BIT   = 5;
  localparam int unsigned CTRL_USED_W         = 6;

  // Field positions of the status register.
  localparam int unsigned STAT_SYNC_NEG_BIT = 0;
  localparam int unsigned STAT_ICP_BIT      = 1;
  localparam int unsigned STAT_INT_BLK_BIT  = 2;
  localparam int unsigned STAT_OCP_BIT      = 3;
  localparam int unsigned STAT_VID_BLK_BIT  = 4;

  // Reset values.
  localparam logic [DATA_W-1:0] CTRL_RST      = 8'h00;
  localparam logic [DATA_W-1:0] ICP_WIDTH_RST = 8'h10;
  localparam logic [DATA_W-1:0] OCP_WIDTH_RST = 8'h08;

  // Width of the sync high/low time counters.
  localparam int unsigned LEN_W = 12;

  // Number of external inputs that are synchronised.
  localparam int unsigned SYNC_BITS = 3;
  localparam int unsigned SYNC_HS_BIT  = 0;
  localparam int unsigned SYNC_BLK_BIT = 1;
  localparam int unsigned SYNC_OVL_BIT = 2;

  // Number of video channels.
  localparam int unsigned CHANNELS = 3;

endpackage

/* File: src/icpg_sync.sv */
module icpg_sync
  import icpg_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Asynchronous inputs and their synchronised copies.
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // Each bit passes two flip-flops; the first is read only by the second.
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_comb
    begin
      meta_d[i] = async_i[i];
      sync_d[i] = meta_q[i];
    end
  end

  // Registers of both stages.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule

/* File: src/icpg_top.sv */
// Function
// - Clamp pulse source is sync or blanking input, chosen in control register 8.
// - Sync of either polarity is rectified automatically before edge selection.
// - Sync source triggers on leading or trailing rectified edge, software selected.
// - Blanking input passes a bypassable inverter, giving the internal blanking signal.
// - Blanking source triggers on the internal blanking edge chosen by software.
// - Clamp pulse width comes from a software-loaded width setting.
// - Pass-through forwards the sync input pulse unprocessed; source drives it active high.
// - The three input clamps are enabled only during the clamp pulse.
// - All three channels blank while internal blanking or overlay insertion is high.
// - Output clamp pulse follows blanking leading edge or copies the clamp pulse.
//
// Implementation choices: the address-and-strobe port and the address map.
module icpg_top
  import icpg_pkg::*;
(
  // Clock and reset.
  input  wire logic                CLK_I,
  input  wire logic                RST_N_I,
  // Video timing pins.
  input  wire logic                HORIZ_SYNC_IN_I,
  input  wire logic                FLYBACK_BLANK_IN_I,
  input  wire logic                OVERLAY_INSERT_CTL_I,
  // Register port.
  input  wire logic [ADDR_W-1:0]   ADDR_I,
  input  wire logic [DATA_W-1:0]   WDATA_I,
  input  wire logic                WR_I,
  input  wire logic                RD_I,
  output logic      [DATA_W-1:0]   RDATA_O,
  // Clamp and blanking outputs.
  output logic                     INPUT_CLAMP_PULSE_O,
  output logic      [CHANNELS-1:0] CLAMP_EN_O,
  output logic                     INTERNAL_BLANK_O,
  output logic      [CHANNELS-1:0] VIDEO_BLANK_O,
  output logic                     OUTPUT_CLAMP_PULSE_O
);

  logic [SYNC_BITS-1:0] pins_s;
  logic                 hs_s;
  logic                 blk_s;
  logic                 ovl_s;

  // Every video timing pin passes the two-stage synchroniser first.
  icpg_sync #(
    .WIDTH (SYNC_BITS)
  ) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .async_i ({OVERLAY_INSERT_CTL_I, FLYBACK_BLANK_IN_I, HORIZ_SYNC_IN_I}),
    .sync_o  (pins_s)
  );

  assign hs_s  = pins_s[SYNC_HS_BIT];
  assign blk_s = pins_s[SYNC_BLK_BIT];
  assign ovl_s = pins_s[SYNC_OVL_BIT];

  // ---------------- Register file ----------------
  logic [DATA_W-1:0] ctrl_q, ctrl_d;
  logic [DATA_W-1:0] icp_width_q, icp_width_d;
  logic [DATA_W-1:0] ocp_width_q, ocp_width_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [DATA_W-1:0] status_w;
  logic              src_blank_w;
  logic              sync_trail_w;
  logic              blk_inv_w;
  logic              blk_fall_sel_w;
  logic              pass_w;
  logic              ocp_copy_w;

  // Control fields that steer the pulse logic.
  assign src_blank_w    = ctrl_q[CTRL_SRC_SEL_BIT];
  assign sync_trail_w   = ctrl_q[CTRL_SYNC_EDGE_BIT];
  assign blk_inv_w      = ctrl_q[CTRL_BLK_INV_BIT];
  assign blk_fall_sel_w = ctrl_q[CTRL_BLK_EDGE_BIT];
  assign pass_w         = ctrl_q[CTRL_PASS_BIT];
  assign ocp_copy_w     = ctrl_q[CTRL_OCP_COPY_BIT];

  // Writes load the settings; reads answer one cycle later, zero otherwise.
  always_comb
  begin
    ctrl_d      = ctrl_q;
    icp_width_d = icp_width_q;
    ocp_width_d = ocp_width_q;
    rdata_d     = '0;
    if (WR_I)
    begin
      case (ADDR_I)
        ADDR_CTRL:      ctrl_d = {{(DATA_W-CTRL_USED_W){1'b0}}, WDATA_I[CTRL_USED_W-1:0]};
        ADDR_ICP_WIDTH: icp_width_d = WDATA_I;
        ADDR_OCP_WIDTH: ocp_width_d = WDATA_I;
        default:        ctrl_d = ctrl_q;
      endcase
    end
    if (RD_I)
    begin
      case (ADDR_I)
        ADDR_CTRL:      rdata_d = ctrl_q;
        ADDR_ICP_WIDTH: rdata_d = icp_width_q;
        ADDR_OCP_WIDTH: rdata_d = ocp_width_q;
        ADDR_STATUS:    rdata_d = status_w;
        default:        rdata_d = '0;
      endcase
    end
  end

  // Register file flip-flops.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      ctrl_q      <= CTRL_RST;
      icp_width_q <= ICP_WIDTH_RST;
      ocp_width_q <= OCP_WIDTH_RST;
      rdata_q     <= '0;
    end
    else
    begin
      ctrl_q      <= ctrl_d;
      icp_width_q <= icp_width_d;
      ocp_width_q <= ocp_width_d;
      rdata_q     <= rdata_d;
    end
  end

  // ---------------- Edge detection and sync polarity ----------------
  logic             hs_prev_q, hs_prev_d;
  logic             ib_prev_q, ib_prev_d;
  logic [LEN_W-1:0] hi_cnt_q, hi_cnt_d;
  logic [LEN_W-1:0] lo_cnt_q, lo_cnt_d;
  logic [LEN_W-1:0] hi_len_q, hi_len_d;
  logic [LEN_W-1:0] lo_len_q, lo_len_d;
  logic             sync_neg_q, sync_neg_d;
  logic             hs_rise_w;
  logic             hs_fall_w;
  logic             lead_w;
  logic             trail_w;
  logic             ib_w;
  logic             ib_rise_w;
  logic             ib_fall_w;
  logic             sync_edge_w;
  logic             blank_edge_w;
  logic             trig_w;

  // Raw sync edges, then rectified edges.
  assign hs_rise_w    = hs_s && !hs_prev_q;
  assign hs_fall_w    = !hs_s && hs_prev_q;
  assign lead_w       = sync_neg_q ? hs_fall_w : hs_rise_w;
  assign trail_w      = sync_neg_q ? hs_rise_w : hs_fall_w;
  assign sync_edge_w  = sync_trail_w ? trail_w : lead_w;
  // Internal blanking after the bypassable inverter.
  assign ib_w         = blk_s ^ blk_inv_w;
  assign ib_rise_w    = ib_w && !ib_prev_q;
  assign ib_fall_w    = !ib_w && ib_prev_q;
  assign blank_edge_w = blk_fall_sel_w ? ib_fall_w : ib_rise_w;
  assign trig_w       = src_blank_w ? blank_edge_w : sync_edge_w;

  // Measure high and low times; the shorter phase is the sync pulse.
  always_comb
  begin
    hs_prev_d  = hs_s;
    ib_prev_d  = ib_w;
    hi_cnt_d   = hi_cnt_q;
    lo_cnt_d   = lo_cnt_q;
    hi_len_d   = hi_len_q;
    lo_len_d   = lo_len_q;
    sync_neg_d = sync_neg_q;
    if (hs_fall_w)
    begin
      hi_len_d   = hi_cnt_q;
      hi_cnt_d   = '0;
      sync_neg_d = hi_cnt_q > lo_len_q;
    end
    else if (hs_s && (hi_cnt_q != {LEN_W{1'b1}}))
    begin
      hi_cnt_d = hi_cnt_q + 1'b1;
    end
    if (hs_rise_w)
    begin
      lo_len_d   = lo_cnt_q;
      lo_cnt_d   = '0;
      sync_neg_d = hi_len_q > lo_cnt_q;
    end
    else if (!hs_s && (lo_cnt_q != {LEN_W{1'b1}}))
    begin
      lo_cnt_d = lo_cnt_q + 1'b1;
    end
  end

  // Edge and polarity flip-flops.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      hs_prev_q  <= 1'b0;
      ib_prev_q  <= 1'b0;
      hi_cnt_q   <= '0;
      lo_cnt_q   <= '0;
      hi_len_q   <= '0;
      lo_len_q   <= '0;
      sync_neg_q <= 1'b0;
    end
    else
    begin
      hs_prev_q  <= hs_prev_d;
      ib_prev_q  <= ib_prev_d;
      hi_cnt_q   <= hi_cnt_d;
      lo_cnt_q   <= lo_cnt_d;
      hi_len_q   <= hi_len_d;
      lo_len_q   <= lo_len_d;
      sync_neg_q <= sync_neg_d;
    end
  end

  // ---------------- Pulse generators and outputs ----------------
  logic [DATA_W-1:0]   icp_cnt_q, icp_cnt_d;
  logic [DATA_W-1:0]   ocp_cnt_q, ocp_cnt_d;
  logic [DATA_W-1:0]   icp_w_eff;
  logic [DATA_W-1:0]   ocp_w_eff;
  logic                icp_q, icp_d;
  logic                ocp_q, ocp_d;
  logic [CHANNELS-1:0] clamp_q, clamp_d;
  logic                ib_q, ib_d;
  logic [CHANNELS-1:0] vblank_q, vblank_d;

  // A zero width is taken as one cycle so a pulse never vanishes.
  assign icp_w_eff = (icp_width_q == '0) ? {{(DATA_W-1){1'b0}}, 1'b1} : icp_width_q;
  assign ocp_w_eff = (ocp_width_q == '0) ? {{(DATA_W-1){1'b0}}, 1'b1} : ocp_width_q;

  // The clamp counter loads on the trigger, the output clamp counter on the internal blanking rise; both run down, a pulse high while nonzero.
  always_comb
  begin
    icp_cnt_d = (icp_cnt_q != '0) ? icp_cnt_q - 1'b1 : '0;
    if (trig_w && !pass_w)
    begin
      icp_cnt_d = icp_w_eff;
    end
    icp_d = pass_w ? hs_s : (icp_cnt_d != '0);
    ocp_cnt_d = (ocp_cnt_q != '0) ? ocp_cnt_q - 1'b1 : '0;
    if (ib_rise_w && !ocp_copy_w)
    begin
      ocp_cnt_d = ocp_w_eff;
    end
    ocp_d    = ocp_copy_w ? icp_d : (ocp_cnt_d != '0);
    clamp_d  = {CHANNELS{icp_d}};
    ib_d     = ib_w;
    vblank_d = {CHANNELS{ib_w || ovl_s}};
  end

  // Pulse and output flip-flops.
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      icp_cnt_q <= '0;
      ocp_cnt_q <= '0;
      icp_q     <= 1'b0;
      ocp_q     <= 1'b0;
      clamp_q   <= '0;
      ib_q      <= 1'b0;
      vblank_q  <= '0;
    end
    else
    begin
      icp_cnt_q <= icp_cnt_d;
      ocp_cnt_q <= ocp_cnt_d;
      icp_q     <= icp_d;
      ocp_q     <= ocp_d;
      clamp_q   <= clamp_d;
      ib_q      <= ib_d;
      vblank_q  <= vblank_d;
    end
  end

  // Status register shows live state of the block.
  always_comb
  begin
    status_w                    = '0;
    status_w[STAT_SYNC_NEG_BIT] = sync_neg_q;
    status_w[STAT_ICP_BIT]      = icp_q;
    status_w[STAT_INT_BLK_BIT]  = ib_q;
    status_w[STAT_OCP_BIT]      = ocp_q;
    status_w[STAT_VID_BLK_BIT]  = vblank_q[0];
  end

  // Output ports come straight from flip-flops.
  assign RDATA_O              = rdata_q;
  assign INPUT_CLAMP_PULSE_O  = icp_q;
  assign CLAMP_EN_O           = clamp_q;
  assign INTERNAL_BLANK_O     = ib_q;
  assign VIDEO_BLANK_O        = vblank_q;
  assign OUTPUT_CLAMP_PULSE_O = ocp_q;

  // ---------------- Assertions ----------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  // A trigger on a quiet generator starts the pulse on the next edge.
  sequence s_sync_trig;
    !pass_w && !src_blank_w && sync_edge_w && !WR_I;
  endsequence
  sequence s_blank_trig;
    !pass_w && src_blank_w && blank_edge_w && !WR_I;
  endsequence
  sequence s_pulse_on;
    INPUT_CLAMP_PULSE_O && CLAMP_EN_O == {CHANNELS{1'b1}};
  endsequence

  property p_sync_src;
    s_sync_trig |=> s_pulse_on;
  endproperty
  a_sync_src: assert property (p_sync_src) else $error("sync edge did not start clamp pulse");

  property p_blank_src;
    s_blank_trig |=> s_pulse_on;
  endproperty
  a_blank_src: assert property (p_blank_src) else $error("blank edge did not start clamp pulse");

  property p_no_trig;
    (!pass_w && icp_cnt_q == '0 && !trig_w && !WR_I) |=> !INPUT_CLAMP_PULSE_O;
  endproperty
  a_no_trig: assert property (p_no_trig) else $error("clamp pulse without trigger");

  property p_width;
    (!pass_w && trig_w && !WR_I && icp_w_eff == icp_width_q && icp_width_q == 8'h03)
      ##1 (!trig_w && !WR_I)[*3] |=> !INPUT_CLAMP_PULSE_O && $past(INPUT_CLAMP_PULSE_O, 3);
  endproperty
  a_width: assert property (p_width) else $error("clamp pulse width differs from setting");

  property p_pass;
    (pass_w && !WR_I) |=> INPUT_CLAMP_PULSE_O == $past(hs_s);
  endproperty
  a_pass: assert property (p_pass) else $error("pass-through pulse not forwarded");

  property p_clamp;
    CLAMP_EN_O == {CHANNELS{INPUT_CLAMP_PULSE_O}};
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamps not aligned with clamp pulse");

  property p_vblank;
    ##1 VIDEO_BLANK_O == {CHANNELS{$past(ib_w) || $past(ovl_s)}};
  endproperty
  a_vblank: assert property (p_vblank) else $error("video blanking wrong");

  property p_inv;
    ##1 INTERNAL_BLANK_O == ($past(blk_s) ^ $past(blk_inv_w));
  endproperty
  a_inv: assert property (p_inv) else $error("internal blanking polarity wrong");

  property p_pol;
    (hs_fall_w && hi_cnt_q > lo_len_q) |=> sync_neg_q;
  endproperty
  a_pol: assert property (p_pol) else $error("sync polarity not rectified");

  property p_ocp;
    (ocp_copy_w && !WR_I) |=> OUTPUT_CLAMP_PULSE_O == INPUT_CLAMP_PULSE_O;
  endproperty
  a_ocp: assert property (p_ocp) else $error("output clamp pulse does not copy clamp pulse");

endmodule

/* File: verification/icpg_video_src.sv */
module icpg_video_src
#(
  parameter int LINE = 48
)
(
  // Clock.
  input  wire logic clk_i,
  // Pin polarities chosen by the bench.
  input  wire logic sync_neg_i,
  input  wire logic blk_neg_i,
  // Video timing pins.
  output logic      hs_o,
  output logic      blk_o
);
  timeunit 1ns;
  timeprecision 100ps;

  int pos = 0;

  // Pins start idle so the design never sees an unknown level.
  initial
  begin
    hs_o = 1'b0;
    blk_o = 1'b0;
  end

  // One line: the flyback pulse spans the line start and the sync pulse sits inside it,
  // so no flyback edge lands inside active video. A positive sync doubles as the clamp pulse.
  always @(posedge clk_i)
  begin
    pos <= (pos == LINE - 1) ? 0 : pos + 1;
    hs_o <= ((pos >= 3) && (pos < 9)) ^ sync_neg_i;
    blk_o <= (pos < 14) ^ blk_neg_i;
  end
endmodule

/* File: verification/icpg_tb_top.sv */
module icpg_tb_top
  import icpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk, rst_n, hs, flyback_blank_in, ovl, wr, rd, input_clamp_pulse, int_blk, output_clamp_pulse, neg, bneg, chk_on;
  logic [7:0] addr, wdata, rdata, m_ctrl, m_iw, m_ow, v;
  logic [2:0] clamp_en, vid_blk;
  logic [8:0] pipe;
  logic       rs, rsp, ib, ibp, trig, e_icp, e_ib, e_vb, e_ocp, m_neg;
  int         ricp, rocp, r, ro, fail_count, samples_checked;
  int         seed = 44812;
  int         ocnt = 0;
  // Control value, sync polarity and flyback polarity for each configuration.
  logic [7:0] cfg_c [6] = '{8'h00, 8'h02, 8'h25, 8'h09, 8'h10, 8'h00};
  logic       cfg_n [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  logic       cfg_b [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

  icpg_top icpg_top_i (
    .CLK_I(clk), .RST_N_I(rst_n), .HORIZ_SYNC_IN_I(hs), .FLYBACK_BLANK_IN_I(flyback_blank_in),
    .OVERLAY_INSERT_CTL_I(ovl), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .INPUT_CLAMP_PULSE_O(input_clamp_pulse), .CLAMP_EN_O(clamp_en),
    .INTERNAL_BLANK_O(int_blk), .VIDEO_BLANK_O(vid_blk), .OUTPUT_CLAMP_PULSE_O(output_clamp_pulse)
  );

  icpg_video_src icpg_video_src_i (
    .clk_i(clk), .sync_neg_i(neg), .blk_neg_i(bneg), .hs_o(hs), .blk_o(flyback_blank_in)
  );

  // Clock generator.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Overlay pin changes at most every fourth cycle so the synchroniser never misses it.
  always @(posedge clk)
  begin
    ro = $random(seed);
    ocnt <= ocnt + 1;
    if (ocnt[1:0] == 2'b00)
      ovl <= ro[0];
  end

  // Reference model: two-stage capture, rectifier, edge pick and width counters.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pipe = '0;
      ricp = 0;
      rocp = 0;
      {e_icp, e_ib, e_vb, e_ocp} = '0;
      m_ctrl = CTRL_RST;
      m_iw = ICP_WIDTH_RST;
      m_ow = OCP_WIDTH_RST;
    end
    else
    begin
      rs = pipe[3] ^ m_neg;
      rsp = pipe[6] ^ m_neg;
      ib = pipe[4] ^ m_ctrl[2];
      ibp = pipe[7] ^ m_ctrl[2];
      trig = m_ctrl[0] ? (m_ctrl[3] ? (ibp & !ib) : (ib & !ibp)) : (m_ctrl[1] ? (rsp & !rs) : (rs & !rsp));
      if (trig)
        ricp = (m_iw == 8'h00) ? 1 : int'(m_iw);
      e_icp = m_ctrl[4] ? pipe[3] : (ricp > 0);
      if (ricp > 0)
        ricp--;
      if (ib & !ibp)
        rocp = (m_ow == 8'h00) ? 1 : int'(m_ow);
      e_ocp = m_ctrl[5] ? e_icp : (rocp > 0);
      if (rocp > 0)
        rocp--;
      e_ib = ib;
      e_vb = ib | pipe[5];
      pipe = {pipe[5:0], ovl, flyback_blank_in, hs};
    end
  end

  // Every clamp and blanking output is compared with the model once per cycle, away from the active edge.
  always @(negedge clk)
  begin
    if (chk_on)
    begin
      chk({7'h00, input_clamp_pulse}, {7'h00, e_icp});
      chk({5'h00, clamp_en}, {5'h00, {3{e_icp}}});
      chk({7'h00, int_blk}, {7'h00, e_ib});
      chk({5'h00, vid_blk}, {5'h00, {3{e_vb}}});
      chk({7'h00, output_clamp_pulse}, {7'h00, e_ocp});
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Register write: one strobe cycle, then an idle edge before the next request.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Register read: the data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if ((fail_count == 0) && (samples_checked > 0))
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard.
  initial
  begin
    #200000;
    fail_count++;
    final_report();
  end

  // Main sequence: reset, register map, then each clamp configuration in turn.
  initial
  begin
    {rst_n, addr, wdata, wr, rd, neg, bneg, chk_on, m_neg} = '0;
    fail_count = 0;
    samples_checked = 0;
    @(posedge clk);
    chk_on = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(ADDR_CTRL, v);
    chk(v, CTRL_RST);
    rd_reg(ADDR_ICP_WIDTH, v);
    chk(v, ICP_WIDTH_RST);
    rd_reg(ADDR_OCP_WIDTH, v);
    chk(v, OCP_WIDTH_RST);
    rd_reg(8'h20, v);
    chk(v, 8'h00);
    chk_on = 1'b0;
    wr_reg(ADDR_CTRL, 8'hff);
    rd_reg(ADDR_CTRL, v);
    chk(v, 8'h3f);
    for (int k = 0; k < 6; k++)
    begin
      chk_on = 1'b0;
      neg <= cfg_n[k];
      bneg <= cfg_b[k];
      m_neg = cfg_n[k];
      r = $random(seed);
      m_iw = (k == 5) ? 8'h00 : {5'h00, r[2:0]} + 8'h01;
      m_ow = (k == 5) ? 8'h00 : {5'h00, r[6:4]} + 8'h01;
      wr_reg(ADDR_ICP_WIDTH, m_iw);
      wr_reg(ADDR_OCP_WIDTH, m_ow);
      wr_reg(ADDR_CTRL, cfg_c[k]);
      m_ctrl = cfg_c[k];
      rd_reg(ADDR_ICP_WIDTH, v);
      chk(v, m_iw);
      repeat (150) @(posedge clk);
      rd_reg(ADDR_STATUS, v);
      chk({7'h00, v[STAT_SYNC_NEG_BIT]}, {7'h00, cfg_n[k]});
      chk_on = 1'b1;
      repeat (120) @(posedge clk);
    end
    final_report();
  end
endmodule
